// ### common/iit_consts.svh
// Purpose: constants of the instruction issue timing controller
// Assumes: one sys_clk at 125 MHz, minor cycle built from it
// Notes: times are in minor cycles unless named _NS (nanoseconds) or _CLKS (sys_clk periods)
//
// Notes on behaviour
// - taken branch leaving stack: target ready after 15 (register) or 14 minor cycles.
// - register branch not taken: 11 cycles in stack or word, 14 to next word.
// - index-compare branch not taken: 10 cycles in stack or word, 13 to next word.
// - constant-zero index register is reserved and stalls issue like any register.
// - no store while an increment unit loads, no load while one stores.
// - instruction word fetches never count as loads or stores.
// - same-cycle operand fetches allowed only for units of different groups.
// - unit execution time never depends on operand values.
// - index jump always invalidates the whole stack.
// - return jump always invalidates the whole stack.
// - computed result is held while its register is an earlier unfetched operand.
// - held result usable as operand the cycle after the blocking fetch.
// - held result register and unit freed two cycles after the fetch; the code frees them one cycle after it.
// - every count is in minor cycles of 100 ns; the code rounds a minor cycle up to 13 clocks of 8 ns, 104 ns.
// - issue only when word in stack, unit free, result register free.
// - unit reissued only one minor cycle after its release.
// - next issue one minor cycle after a short, two after a long instruction.
`ifndef IIT_CONSTS_SVH
`define IIT_CONSTS_SVH

`define IIT_NUM_UNITS 9
`define IIT_NUM_REGS 24
`define IIT_REG_B0 5'h10
`define IIT_UNIT_INC1 4'h7
`define IIT_UNIT_INC2 4'h8

`define IIT_MINOR_NS 100
`define IIT_CLK_NS 8
`define IIT_MINOR_CLKS ((`IIT_MINOR_NS + `IIT_CLK_NS - 1) / `IIT_CLK_NS)

`define IIT_GAP_SHORT 8'h01
`define IIT_GAP_LONG 8'h02
`define IIT_BR_IN_TAKEN 8'h09
`define IIT_BR_RC_OUT 8'h0F
`define IIT_BR_OTHER_OUT 8'h0E
`define IIT_BR_RC_NT_IN 8'h0B
`define IIT_BR_RC_NT_OUT 8'h0E
`define IIT_BR_IX_NT_IN 8'h0A
`define IIT_BR_IX_NT_OUT 8'h0D

`define IIT_LAT_G1 6'h0A
`define IIT_LAT_G2 6'h04
`define IIT_LAT_G3 6'h03

`endif

// ### common/iit_pkg.sv
// Purpose: types of the instruction issue timing controller
// Assumes: register numbers X0-X7 = 0-7, A0-A7 = 8-15, B0-B7 = 16-23
// Notes: unit numbers 0-3 group one, 4-6 group two, 7-8 group three
`include "iit_consts.svh"
package iit_pkg;
	typedef enum logic [2:0] {IIT_BR_NONE, IIT_BR_REGCOND, IIT_BR_IDXCMP, IIT_BR_OTHER,
		IIT_BR_IDXJUMP, IIT_BR_RETJUMP} iit_br_e;
	typedef enum logic [1:0] {IIT_MEM_NONE, IIT_MEM_LOAD, IIT_MEM_STORE} iit_mem_e;
	typedef enum logic [2:0] {IIT_U_IDLE, IIT_U_FETCH, IIT_U_EXEC, IIT_U_HOLD, IIT_U_STORE} iit_ust_e;
	typedef struct packed {
		logic [3:0] unit;
		logic res_en;
		logic [4:0] res_reg;
		logic opj_en;
		logic [4:0] opj;
		logic opk_en;
		logic [4:0] opk;
		logic is_long;
		iit_mem_e mem;
		iit_br_e br;
		logic br_taken;
		logic br_out_stack;
	} iit_ins_s;
endpackage

// ### rtl/iit_issue_ctrl.sv
// Purpose: issue gating, unit and register reservation, branch timing
// Assumes: stack and functional units share sys_clk; ins held until issue_ff
// Notes: issue and unit state advances once per minor cycle on tick_ff; refill_ff clears on any clock
`timescale 1ns/1ps
`include "iit_consts.svh"
module iit_issue_ctrl
	import iit_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// instruction stack
	input wire logic ins_valid,
	input wire iit_ins_s ins,
	input wire logic ins_in_stack,
	input wire logic word_loaded,
	// issue and stack control
	output logic issue_ff,
	output logic stack_inval_ff,
	output logic refill_ff,
	// functional units
	output logic [`IIT_NUM_UNITS-1:0] unit_busy_ff,
	output logic [`IIT_NUM_UNITS-1:0] fetch_go_ff,
	output logic [`IIT_NUM_UNITS-1:0] store_go_ff
);
	localparam int NU = `IIT_NUM_UNITS;
	localparam int NR = `IIT_NUM_REGS;

	logic [3:0] tick_cnt_ff;
	logic tick_ff;
	logic [7:0] gap_ff;
	iit_ust_e ust_ff [NU];
	logic [4:0] dst_ff [NU];
	logic [NU-1:0] dst_en_ff;
	logic [4:0] opj_ff [NU];
	logic [4:0] opk_ff [NU];
	logic [NU-1:0] opj_en_ff;
	logic [NU-1:0] opk_en_ff;
	logic [NU-1:0] wj_ff;
	logic [NU-1:0] wk_ff;
	iit_mem_e mem_ff [NU];
	logic [5:0] cnt_ff [NU];
	logic [NR-1:0] res_busy;
	logic [NR-1:0] opnd_res;
	logic [NR-1:0] blk;
	logic [NR-1:0] rel_now;
	logic [NU-1:0] req;
	logic [NU-1:0] grant;
	logic inc_load;
	logic inc_store;
	logic ldst_ok;
	logic take;
	logic [7:0] nxt_gap;

	function automatic logic [1:0] unit_grp(input int u);
		unit_grp = (u < 4) ? 2'h0 : (u < 7) ? 2'h1 : 2'h2;
	endfunction

	function automatic logic [5:0] unit_lat(input int u);
		unit_lat = (u < 4) ? `IIT_LAT_G1 : (u < 7) ? `IIT_LAT_G2 : `IIT_LAT_G3;
	endfunction

	// ----------------------------------------
	// minor cycle tick
	// ----------------------------------------
	// 100 ns does not divide by 8 ns, so a minor cycle is rounded up to 13 clocks
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tick_cnt_ff <= 4'h0;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff == 4'(`IIT_MINOR_CLKS - 1)) begin
			tick_cnt_ff <= 4'h0;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 4'h1;
			tick_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// reservations
	// ----------------------------------------
	always_comb begin
		res_busy = '0;
		opnd_res = '0;
		blk = '0;
		rel_now = '0;
		for (int u = 0; u < NU; u++) begin
			// constant-zero index register gets no exemption here
			if (ust_ff[u] != IIT_U_IDLE && dst_en_ff[u]) begin
				res_busy[dst_ff[u]] = 1'b1;
			end
			if (ust_ff[u] == IIT_U_FETCH || ust_ff[u] == IIT_U_EXEC || ust_ff[u] == IIT_U_HOLD) begin
				if (dst_en_ff[u]) begin
					blk[dst_ff[u]] = 1'b1;
				end
			end
			// an operand still waiting on its producer wants the new value, so it holds nobody
			if (ust_ff[u] == IIT_U_FETCH) begin
				if (opj_en_ff[u] && !wj_ff[u]) begin
					opnd_res[opj_ff[u]] = 1'b1;
				end
				if (opk_en_ff[u] && !wk_ff[u]) begin
					opnd_res[opk_ff[u]] = 1'b1;
				end
			end
		end
		for (int u = 0; u < NU; u++) begin
			if (dst_en_ff[u] && (ust_ff[u] == IIT_U_STORE ||
				(ust_ff[u] == IIT_U_HOLD && !opnd_res[dst_ff[u]]))) begin
				rel_now[dst_ff[u]] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// operand fetch, one unit per group
	// ----------------------------------------
	always_comb begin
		logic [2:0] used;
		used = 3'h0;
		req = '0;
		grant = '0;
		for (int u = 0; u < NU; u++) begin
			// waits only on producers issued before it, so a later writer cannot lock it out
			req[u] = (ust_ff[u] == IIT_U_FETCH) &&
				!(wj_ff[u] && !rel_now[opj_ff[u]]) &&
				!(wk_ff[u] && !rel_now[opk_ff[u]]);
			if (req[u] && !used[unit_grp(u)]) begin
				grant[u] = 1'b1;
				used[unit_grp(u)] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// issue decision
	// ----------------------------------------
	// only issued memory instructions count; word fetches never reach these terms
	always_comb begin
		inc_load = 1'b0;
		inc_store = 1'b0;
		for (int u = 7; u < NU; u++) begin
			if (ust_ff[u] != IIT_U_IDLE && mem_ff[u] == IIT_MEM_LOAD) begin
				inc_load = 1'b1;
			end
			if (ust_ff[u] != IIT_U_IDLE && mem_ff[u] == IIT_MEM_STORE) begin
				inc_store = 1'b1;
			end
		end
		ldst_ok = !(ins.mem == IIT_MEM_STORE && inc_load) && !(ins.mem == IIT_MEM_LOAD && inc_store);
		take = tick_ff && ins_valid && ins_in_stack && !refill_ff && gap_ff == 8'h00 &&
			ust_ff[ins.unit] == IIT_U_IDLE && ldst_ok && !(ins.res_en && res_busy[ins.res_reg]);
	end

	always_comb begin
		case (ins.br)
			IIT_BR_REGCOND: begin
				if (ins.br_taken) begin
					nxt_gap = ins.br_out_stack ? `IIT_BR_RC_OUT : `IIT_BR_IN_TAKEN;
				end else begin
					nxt_gap = ins.br_out_stack ? `IIT_BR_RC_NT_OUT : `IIT_BR_RC_NT_IN;
				end
			end
			IIT_BR_IDXCMP, IIT_BR_OTHER: begin
				if (ins.br_taken) begin
					nxt_gap = ins.br_out_stack ? `IIT_BR_OTHER_OUT : `IIT_BR_IN_TAKEN;
				end else begin
					nxt_gap = ins.br_out_stack ? `IIT_BR_IX_NT_OUT : `IIT_BR_IX_NT_IN;
				end
			end
			IIT_BR_IDXJUMP, IIT_BR_RETJUMP: begin
				nxt_gap = `IIT_BR_OTHER_OUT;
			end
			default: begin
				nxt_gap = ins.is_long ? `IIT_GAP_LONG : `IIT_GAP_SHORT;
			end
		endcase
	end

	// ----------------------------------------
	// issue spacing and stack control
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			gap_ff <= 8'h00;
			issue_ff <= 1'b0;
			stack_inval_ff <= 1'b0;
		end else if (tick_ff) begin
			issue_ff <= take;
			stack_inval_ff <= take && (ins.br == IIT_BR_IDXJUMP || ins.br == IIT_BR_RETJUMP);
			if (take) begin
				gap_ff <= nxt_gap - 8'h01;
			end else if (gap_ff != 8'h00) begin
				gap_ff <= gap_ff - 8'h01;
			end
		end
	end

	// set wins over a word arriving in the same clock
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			refill_ff <= 1'b0;
		end else if (take && (ins.br == IIT_BR_IDXJUMP || ins.br == IIT_BR_RETJUMP)) begin
			refill_ff <= 1'b1;
		end else if (word_loaded) begin
			refill_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// functional unit sequencing
	// ----------------------------------------
	for (genvar g = 0; g < NU; g++) begin : g_unit
		always_ff @(posedge sys_clk) begin
			if (!reset_n) begin
				ust_ff[g] <= IIT_U_IDLE;
				dst_ff[g] <= 5'h00;
				dst_en_ff[g] <= 1'b0;
				opj_ff[g] <= 5'h00;
				opk_ff[g] <= 5'h00;
				opj_en_ff[g] <= 1'b0;
				opk_en_ff[g] <= 1'b0;
				wj_ff[g] <= 1'b0;
				wk_ff[g] <= 1'b0;
				mem_ff[g] <= IIT_MEM_NONE;
				cnt_ff[g] <= 6'h00;
				fetch_go_ff[g] <= 1'b0;
				store_go_ff[g] <= 1'b0;
			end else if (tick_ff) begin
				fetch_go_ff[g] <= grant[g];
				store_go_ff[g] <= 1'b0;
				case (ust_ff[g])
					IIT_U_IDLE: begin
						if (take && ins.unit == 4'(g)) begin
							ust_ff[g] <= IIT_U_FETCH;
							dst_ff[g] <= ins.res_reg;
							dst_en_ff[g] <= ins.res_en;
							opj_ff[g] <= ins.opj;
							opk_ff[g] <= ins.opk;
							opj_en_ff[g] <= ins.opj_en;
							opk_en_ff[g] <= ins.opk_en;
							wj_ff[g] <= ins.opj_en && blk[ins.opj] && !rel_now[ins.opj];
							wk_ff[g] <= ins.opk_en && blk[ins.opk] && !rel_now[ins.opk];
							mem_ff[g] <= ins.mem;
						end
					end
					IIT_U_FETCH: begin
						if (rel_now[opj_ff[g]]) begin
							wj_ff[g] <= 1'b0;
						end
						if (rel_now[opk_ff[g]]) begin
							wk_ff[g] <= 1'b0;
						end
						if (grant[g]) begin
							ust_ff[g] <= IIT_U_EXEC;
							cnt_ff[g] <= unit_lat(g) - 6'h01;
						end
					end
					IIT_U_EXEC: begin
						if (cnt_ff[g] != 6'h00) begin
							cnt_ff[g] <= cnt_ff[g] - 6'h01;
						end else if (dst_en_ff[g] && opnd_res[dst_ff[g]]) begin
							ust_ff[g] <= IIT_U_HOLD;
						end else begin
							ust_ff[g] <= IIT_U_STORE;
							store_go_ff[g] <= 1'b1;
						end
					end
					IIT_U_HOLD: begin
						// fetch seen one tick ago, so store and release land one after it
						if (!opnd_res[dst_ff[g]]) begin
							ust_ff[g] <= IIT_U_IDLE;
							store_go_ff[g] <= 1'b1;
						end
					end
					IIT_U_STORE: begin
						ust_ff[g] <= IIT_U_IDLE;
					end
					default: begin
						ust_ff[g] <= IIT_U_IDLE;
					end
				endcase
			end
		end

		always_ff @(posedge sys_clk) begin
			if (!reset_n) begin
				unit_busy_ff[g] <= 1'b0;
			end else begin
				unit_busy_ff[g] <= ust_ff[g] != IIT_U_IDLE;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_jump_take;
		take && (ins.br == IIT_BR_IDXJUMP || ins.br == IIT_BR_RETJUMP);
	endsequence
	sequence s_inval_seen;
		stack_inval_ff && refill_ff;
	endsequence

	property p_gap_block;
		gap_ff != 8'h00 |-> !take;
	endproperty
	a_gap_block: assert property (p_gap_block) else $error("issue inside spacing gap");

	property p_short_long;
		take && ins.br == IIT_BR_NONE |=> gap_ff == (ins.is_long ? 8'h01 : 8'h00);
	endproperty
	a_short_long: assert property (p_short_long) else $error("wrong short or long spacing");

	property p_rc_out;
		take && ins.br == IIT_BR_REGCOND && ins.br_taken && ins.br_out_stack |=> gap_ff == 8'h0E;
	endproperty
	a_rc_out: assert property (p_rc_out) else $error("register branch out of stack not 15");

	property p_rc_nt;
		take && ins.br == IIT_BR_REGCOND && !ins.br_taken && !ins.br_out_stack |=> gap_ff == 8'h0A;
	endproperty
	a_rc_nt: assert property (p_rc_nt) else $error("register branch fall through not 11");

	property p_ix_nt_out;
		take && ins.br == IIT_BR_IDXCMP && !ins.br_taken && ins.br_out_stack |=> gap_ff == 8'h0C;
	endproperty
	a_ix_nt_out: assert property (p_ix_nt_out) else $error("index branch next word not 13");

	property p_res_free;
		take && ins.res_en |-> !res_busy[ins.res_reg];
	endproperty
	a_res_free: assert property (p_res_free) else $error("issue onto reserved result register");

	property p_ldst;
		take |-> !(ins.mem == IIT_MEM_STORE && inc_load) && !(ins.mem == IIT_MEM_LOAD && inc_store);
	endproperty
	a_ldst: assert property (p_ldst) else $error("load and store mixed on increment units");

	property p_group;
		$onehot0(grant[3:0]) && $onehot0(grant[6:4]) && $onehot0(grant[8:7]);
	endproperty
	a_group: assert property (p_group) else $error("two fetches in one group");

	property p_inval;
		s_jump_take |=> s_inval_seen;
	endproperty
	a_inval: assert property (p_inval) else $error("jump did not invalidate stack");

	property p_refill;
		refill_ff |-> !take;
	endproperty
	a_refill: assert property (p_refill) else $error("issue before stack refilled");

	property p_hold;
		tick_ff && ust_ff[7] == IIT_U_EXEC && cnt_ff[7] == 6'h00 && dst_en_ff[7] && opnd_res[dst_ff[7]]
			|=> ust_ff[7] == IIT_U_HOLD && !store_go_ff[7];
	endproperty
	a_hold: assert property (p_hold) else $error("result stored over unfetched operand");
endmodule

// ### testbench/iit_stack_model.sv
// Purpose: instruction stack partner of the issue controller
// Assumes: refill_ff is a level from the controller
// Notes: word_loaded changes on falling edges, like the bench; ins_in_stack follows refill_ff directly
`timescale 1ns/1ps
module iit_stack_model #(parameter int LOAD_CLKS = 260) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// stack side
	input wire logic refill_ff,
	output logic word_loaded = 1'b0,
	output logic ins_in_stack
);
	int cnt = 0;
	// stack stays invalid until the new word lands
	assign ins_in_stack = !refill_ff;
	// a word fetch is memory traffic only, never a load or store
	always @(negedge sys_clk) begin
		word_loaded <= 1'b0;
		cnt <= (reset_n && refill_ff && !word_loaded) ? cnt + 1 : 0;
		if (cnt == LOAD_CLKS - 1)
			word_loaded <= 1'b1;
	end
endmodule

// ### testbench/instruction_issue_timing_tb_top.sv
// Purpose: self-checking bench of the issue controller
// Assumes: stimulus on falling edges, stack model answers refills
// Notes: gaps are measured between issue_ff samples at the start of each minor cycle
`timescale 1ns/1ps
`include "iit_consts.svh"
module instruction_issue_timing_tb_top
	import iit_pkg::*;
;
	localparam int MC = `IIT_MINOR_CLKS;
	logic sys_clk;
	logic reset_n;
	logic ins_valid;
	iit_ins_s ins;
	logic ins_in_stack;
	logic word_loaded;
	logic issue_ff;
	logic stack_inval_ff;
	logic refill_ff;
	logic [`IIT_NUM_UNITS-1:0] unit_busy_ff;
	logic [`IIT_NUM_UNITS-1:0] fetch_go_ff;
	logic [`IIT_NUM_UNITS-1:0] store_go_ff;
	int err_total, check_count, cyc, rises, rise_at, inv_n, wl_at, fe5, fe6, st7, t_a, t_b, ph;

	iit_issue_ctrl u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ins_valid(ins_valid), .ins(ins),
		.ins_in_stack(ins_in_stack), .word_loaded(word_loaded), .issue_ff(issue_ff),
		.stack_inval_ff(stack_inval_ff), .refill_ff(refill_ff), .unit_busy_ff(unit_busy_ff),
		.fetch_go_ff(fetch_go_ff), .store_go_ff(store_go_ff));
	iit_stack_model u_stack (.sys_clk(sys_clk), .reset_n(reset_n), .refill_ff(refill_ff),
		.word_loaded(word_loaded), .ins_in_stack(ins_in_stack));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc++;
	// issue_ff stays high through back-to-back takes, so count it once per minor cycle
	always @(posedge sys_clk) begin
		if (!reset_n)
			ph <= 0;
		else
			ph <= (ph == MC - 1) ? 0 : ph + 1;
	end
	always @(negedge sys_clk) begin
		if (reset_n && ph == 1 && issue_ff === 1'b1) begin
			rise_at = cyc;
			rises++;
		end
	end
	always @(posedge stack_inval_ff) inv_n++;
	always @(posedge word_loaded) wl_at = cyc;
	always @(posedge fetch_go_ff[5]) fe5 = cyc;
	always @(posedge fetch_go_ff[6]) fe6 = cyc;
	always @(posedge store_go_ff[7]) st7 = cyc;
	// one operand fetch per group per minor cycle
	always @(negedge sys_clk) begin
		if (reset_n)
			chk($countones(fetch_go_ff[3:0]) < 2 && $countones(fetch_go_ff[6:4]) < 2 &&
				$countones(fetch_go_ff[8:7]) < 2, 1);
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	function automatic iit_ins_s mk(input logic [3:0] u, input logic [4:0] r);
		mk = '0;
		mk.unit = u;
		mk.res_en = 1'b1;
		mk.res_reg = r;
	endfunction
	// ins held until issue seen, then free for the next one
	task automatic send(input iit_ins_s i, output int at);
		int n;
		n = rises;
		@(negedge sys_clk);
		ins_valid = 1'b1;
		ins = i;
		for (int k = 0; k < 3000 && rises == n; k++) @(negedge sys_clk);
		chk(rises != n, 1);
		at = rise_at;
	endtask
	// waits out busy units and the reuse delay after release
	task automatic settle;
		ins_valid = 1'b0;
		for (int k = 0; k < 900 && (unit_busy_ff !== '0 || refill_ff !== 1'b0); k++) @(negedge sys_clk);
		repeat (2 * MC) @(negedge sys_clk);
	endtask
	task automatic pair(input iit_ins_s a, input iit_ins_s b);
		send(a, t_a);
		send(b, t_b);
		settle();
	endtask

	task automatic t_spacing;
		iit_ins_s a;
		pair(mk(4'h4, 5'h01), mk(4'h5, 5'h02));
		chk(t_b - t_a, `IIT_GAP_SHORT * MC);
		a = mk(4'h1, 5'h03);
		a.is_long = 1'b1;
		pair(a, mk(4'h6, 5'h04));
		chk(t_b - t_a, `IIT_GAP_LONG * MC);
	endtask
	task automatic t_branch;
		iit_br_e bk[8] = '{IIT_BR_REGCOND, IIT_BR_OTHER, IIT_BR_IDXCMP, IIT_BR_REGCOND,
			IIT_BR_REGCOND, IIT_BR_IDXCMP, IIT_BR_IDXCMP, IIT_BR_IDXCMP};
		logic [7:0] ex[8] = '{`IIT_BR_RC_OUT, `IIT_BR_OTHER_OUT, `IIT_BR_OTHER_OUT, `IIT_BR_RC_NT_IN,
			`IIT_BR_RC_NT_OUT, `IIT_BR_IX_NT_IN, `IIT_BR_IX_NT_OUT, `IIT_BR_IN_TAKEN};
		logic [7:0] tk = 8'h87;
		logic [7:0] ou = 8'h57;
		iit_ins_s a;
		int n;
		n = inv_n;
		for (int k = 0; k < 8; k++) begin
			a = mk(`IIT_UNIT_INC1, 5'h00);
			a.res_en = 1'b0;
			a.br = bk[k];
			a.br_taken = tk[k];
			a.br_out_stack = ou[k];
			pair(a, mk(4'h4, 5'h05));
			chk(t_b - t_a, ex[k] * MC);
		end
		chk(inv_n - n, 0);
	endtask
	task automatic t_jump;
		iit_ins_s a;
		int n;
		for (int k = 0; k < 2; k++) begin
			n = inv_n;
			a = mk(`IIT_UNIT_INC2, 5'h00);
			a.res_en = 1'b0;
			a.br = k ? IIT_BR_RETJUMP : IIT_BR_IDXJUMP;
			a.br_taken = 1'b1;
			a.br_out_stack = 1'b1;
			pair(a, mk(4'h4, 5'h06));
			chk(inv_n - n, 1);
			chk(wl_at > t_a && wl_at < t_b && t_b - t_a >= `IIT_BR_OTHER_OUT * MC, 1);
		end
	endtask
	task automatic t_ldst;
		iit_ins_s a;
		iit_ins_s b;
		for (int k = 0; k < 3; k++) begin
			a = mk(`IIT_UNIT_INC1, 5'h09);
			b = mk(`IIT_UNIT_INC2, 5'h0A);
			a.mem = (k == 1) ? IIT_MEM_STORE : IIT_MEM_LOAD;
			b.mem = (k == 0) ? IIT_MEM_STORE : IIT_MEM_LOAD;
			pair(a, b);
			chk((k == 2) ? (t_b - t_a == MC) : (t_b - t_a > MC), 1);
		end
	endtask
	task automatic t_reserve;
		pair(mk(4'h4, `IIT_REG_B0), mk(4'h5, `IIT_REG_B0));
		chk(t_b - t_a > MC, 1);
		pair(mk(4'h4, 5'h01), mk(4'h4, 5'h02));
		chk(t_b - t_a > (`IIT_LAT_G2 + 1) * MC, 1);
	endtask
	// two group-one units and a shift all wait on the divide result
	task automatic t_hold;
		iit_ins_s i;
		int t;
		send(mk(4'h0, 5'h03), t);
		i = mk(4'h1, 5'h00);
		i.opj_en = 1'b1;
		i.opj = 5'h03;
		send(i, t);
		i.unit = 4'h2;
		i.res_reg = 5'h01;
		send(i, t);
		i.unit = 4'h5;
		i.res_reg = 5'h07;
		i.opk_en = 1'b1;
		i.opk = 5'h06;
		send(i, t);
		send(mk(`IIT_UNIT_INC1, 5'h06), t);
		i = mk(4'h6, 5'h08);
		i.opj_en = 1'b1;
		i.opj = 5'h06;
		send(i, t);
		settle();
		// held store and the waiting fetch of unit 6 both run the minor cycle after the fetch
		chk(st7 - fe5, MC);
		chk(fe6 - fe5, MC);
	endtask

	task automatic complete_run;
		if (err_total == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_total++;
		complete_run();
	end
	initial begin
		reset_n = 1'b0;
		ins_valid = 1'b0;
		ins = '0;
		repeat (4) @(negedge sys_clk);
		reset_n = 1'b1;
		t_spacing();
		t_branch();
		t_jump();
		t_ldst();
		t_reserve();
		t_hold();
		complete_run();
	end
endmodule
